// *** rtl/eeprom_ctrl_pkg.sv ***
package eeprom_ctrl_pkg;

  // ****************************************
  // bus identifiers and command bytes
  // ****************************************
  localparam logic [6:0] ID_EEPROM    = 7'h50;
  localparam logic [6:0] ID_CSR       = 7'h52;
  localparam logic [6:0] ID_POT       = 7'h57;
  localparam logic [7:0] CSR_ADDR     = 8'hff;
  localparam logic [7:0] CMD_EN_SET   = 8'h02;
  localparam logic [7:0] CMD_EN_CLR   = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ****************************************
  // control_and_status layout
  // ****************************************
  localparam int         CSR_LOCK_HI  = 4;
  localparam int         CSR_LOCK_LO  = 3;
  localparam int         CSR_UNLOCK   = 2;
  localparam int         CSR_EN       = 1;
  localparam logic [1:0] LOCK_RST     = 2'h0;
  localparam logic [1:0] LOCK_NONE    = 2'h0;
  localparam logic [1:0] LOCK_QUARTER = 2'h1;
  localparam logic [1:0] LOCK_HALF    = 2'h2;
  localparam logic [7:0] LIM_QUARTER  = 8'hc0;
  localparam logic [7:0] LIM_HALF     = 8'h80;

  // ****************************************
  // link state machine
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE,
    S_DEV,
    S_WADDR,
    S_WDATA,
    S_ACK,
    S_RDATA,
    S_RACK,
    S_IGNORE
  } link_state_t;

endpackage

// *** rtl/eeprom_read_and_write_enable_ctrl.sv ***
`timescale 1ns/100ps
module eeprom_read_and_write_enable_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic       sys_clk_i,
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output wire logic       sda_o,
  output wire logic       sda_oe_o,
  output      logic [7:0] control_and_status_o,
  output      logic       csr_update_o
);
  import eeprom_ctrl_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  localparam int DEPTH = 1 << ADDR_W;

  logic [2:0]        scl_s_q;
  logic [2:0]        sda_s_q;
  link_state_t       state_q;
  link_state_t       nxt_q;
  logic [3:0]        cnt_q;
  logic [7:0]        sh_q;
  logic [7:0]        tx_q;
  logic              sda_oe_q;
  logic              is_csr_q;
  logic              dummy_q;
  logic              cur_ok_q;
  logic              wr_pend_q;
  logic              data_ok_q;
  logic              byte_seen_q;
  logic              mack_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [7:0]        wr_data_q;
  logic              wr_en_q;
  logic              unlock_q;
  logic [1:0]        lock_q;
  logic              tgl_q;
  logic [2:0]        tgl_s_q;
  logic [7:0]        mem [DEPTH];

  logic              scl;
  logic              sda;
  logic              rise_e;
  logic              fall_e;
  logic              start_e;
  logic              stop_e;
  logic              byte_end;
  logic              rd_load;
  logic              mem_we;
  logic              csr_we;
  logic              lock_hit;
  logic              ee_ok;
  logic              csr_ok;
  logic [7:0]        csr_byte;
  logic [7:0]        rd_byte;

  function automatic logic locked(input logic [7:0] a, input logic [1:0] l);
    case (l)
      LOCK_NONE:    locked = 1'b0;
      LOCK_QUARTER: locked = (a >= LIM_QUARTER);
      LOCK_HALF:    locked = (a >= LIM_HALF);
      default:      locked = 1'b1;
    endcase
  endfunction

  // ****************************************
  // pin synchronisers and bus events
  // ****************************************
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  assign scl     = scl_s_q[1];
  assign sda     = sda_s_q[1];
  assign rise_e  = scl & ~scl_s_q[2];
  assign fall_e  = ~scl & scl_s_q[2];
  assign start_e = scl & scl_s_q[2] & sda_s_q[2] & ~sda;
  assign stop_e  = scl & scl_s_q[2] & ~sda_s_q[2] & sda;

  // ****************************************
  // decode
  // ****************************************
  assign byte_end = fall_e && cnt_q == BITS_PER_BYTE &&
                    (state_q == S_DEV || state_q == S_WADDR || state_q == S_WDATA);
  assign csr_byte = {3'h0, lock_q, unlock_q, wr_en_q, 1'b0};
  assign rd_byte  = is_csr_q ? csr_byte : mem[ptr_q];
  assign rd_load  = fall_e && ((state_q == S_ACK && nxt_q == S_RDATA) ||
                    (state_q == S_RACK && mack_q && !is_csr_q));
  assign ee_ok    = wr_en_q && !locked(ptr_q, lock_q);
  assign csr_ok   = wr_en_q || sh_q == CMD_EN_SET || sh_q == CMD_EN_CLR;
  assign lock_hit = byte_end && state_q == S_WDATA && !is_csr_q && !byte_seen_q &&
                    locked(ptr_q, lock_q);
  assign mem_we   = stop_e && data_ok_q && !is_csr_q;
  assign csr_we   = stop_e && data_ok_q && is_csr_q;

  // ****************************************
  // link state machine
  // ****************************************
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= S_IDLE;
      nxt_q       <= S_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      sda_oe_q    <= 1'b0;
      is_csr_q    <= 1'b0;
      dummy_q     <= 1'b0;
      wr_pend_q   <= 1'b0;
      data_ok_q   <= 1'b0;
      byte_seen_q <= 1'b0;
      mack_q      <= 1'b0;
      wr_addr_q   <= '0;
      wr_data_q   <= 8'h00;
    end else if (start_e) begin
      state_q     <= S_DEV;
      cnt_q       <= 4'h0;
      sda_oe_q    <= 1'b0;
      wr_pend_q   <= 1'b0;
      data_ok_q   <= 1'b0;
      byte_seen_q <= 1'b0;
    end else if (stop_e) begin
      state_q   <= S_IDLE;
      cnt_q     <= 4'h0;
      sda_oe_q  <= 1'b0;
      data_ok_q <= 1'b0;
      dummy_q   <= 1'b0;
    end else begin
      case (state_q)
        S_DEV, S_WADDR, S_WDATA: begin
          if (rise_e) begin
            sh_q  <= {sh_q[6:0], sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_q   <= 4'h0;
            state_q <= S_IGNORE;
            if (state_q == S_DEV) begin
              if (sh_q[7:1] == ID_EEPROM) begin
                is_csr_q <= 1'b0;
                if (!sh_q[0]) begin
                  state_q  <= S_ACK;
                  sda_oe_q <= 1'b1;
                  nxt_q    <= S_WADDR;
                end else if (cur_ok_q || dummy_q) begin
                  state_q  <= S_ACK;
                  sda_oe_q <= 1'b1;
                  nxt_q    <= S_RDATA;
                end
              end else if (sh_q[7:1] == ID_CSR) begin
                is_csr_q <= 1'b1;
                if (!sh_q[0] || dummy_q) begin
                  state_q  <= S_ACK;
                  sda_oe_q <= 1'b1;
                  nxt_q    <= sh_q[0] ? S_RDATA : S_WADDR;
                end
              end else if (sh_q[7:1] == ID_POT) begin
                state_q  <= S_ACK;
                sda_oe_q <= 1'b1;
                nxt_q    <= S_IGNORE;
              end
            end else if (state_q == S_WADDR) begin
              if (!is_csr_q || sh_q == CSR_ADDR) begin
                state_q  <= S_ACK;
                sda_oe_q <= 1'b1;
                nxt_q    <= S_WDATA;
                dummy_q  <= 1'b1;
              end
            end else if (byte_seen_q) begin
              data_ok_q <= 1'b0;
            end else if (is_csr_q ? csr_ok : ee_ok) begin
              state_q     <= S_ACK;
              sda_oe_q    <= 1'b1;
              nxt_q       <= S_WDATA;
              wr_pend_q   <= 1'b1;
              byte_seen_q <= 1'b1;
              wr_data_q   <= sh_q;
              wr_addr_q   <= ptr_q;
            end
          end
        end
        S_ACK: begin
          if (fall_e) begin
            state_q   <= nxt_q;
            sda_oe_q  <= 1'b0;
            data_ok_q <= data_ok_q | wr_pend_q;
            wr_pend_q <= 1'b0;
            if (nxt_q == S_RDATA) begin
              tx_q     <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end
          end
        end
        S_RDATA: begin
          if (rise_e) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (fall_e) begin
            if (cnt_q == BITS_PER_BYTE) begin
              state_q  <= S_RACK;
              sda_oe_q <= 1'b0;
              cnt_q    <= 4'h0;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
        end
        S_RACK: begin
          if (rise_e) begin
            mack_q <= ~sda;
          end else if (fall_e) begin
            if (mack_q && !is_csr_q) begin
              state_q  <= S_RDATA;
              tx_q     <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end else begin
              state_q <= S_IGNORE;
            end
          end
        end
        S_IDLE, S_IGNORE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // ****************************************
  // address counter and read availability
  // ****************************************
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q <= '0;
    end else if (byte_end && state_q == S_WADDR && !is_csr_q) begin
      ptr_q <= sh_q[ADDR_W-1:0];
    end else if (rd_load && !is_csr_q) begin
      ptr_q <= ptr_q + 1'b1;
    end else if (mem_we) begin
      ptr_q <= wr_addr_q + 1'b1;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ok_q <= 1'b0;
    end else if (byte_end && state_q == S_DEV) begin
      if (sh_q[7:1] == ID_CSR || sh_q[7:1] == ID_POT) begin
        cur_ok_q <= 1'b0;
      end else if (sh_q[7:1] == ID_EEPROM && sh_q[0] && dummy_q) begin
        cur_ok_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (mem_we) begin
      mem[wr_addr_q] <= wr_data_q;
    end
  end

  // ****************************************
  // control_and_status register
  // ****************************************
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_en_q  <= 1'b0;
      unlock_q <= 1'b0;
      lock_q   <= LOCK_RST;
    end else if (csr_we) begin
      if (unlock_q && !wr_data_q[CSR_UNLOCK]) begin
        lock_q   <= wr_data_q[CSR_LOCK_HI:CSR_LOCK_LO];
        wr_en_q  <= wr_data_q[CSR_EN];
        unlock_q <= 1'b0;
      end else if (wr_data_q[CSR_UNLOCK] && wr_en_q) begin
        unlock_q <= 1'b1;
        wr_en_q  <= wr_data_q[CSR_EN];
      end else begin
        wr_en_q  <= wr_data_q[CSR_EN];
      end
    end else if (lock_hit) begin
      unlock_q <= 1'b0;
    end
  end

  // ****************************************
  // status hand-off to system clock
  // ****************************************
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_q <= 1'b0;
    end else if (csr_we || lock_hit) begin
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_s_q              <= 3'h0;
      control_and_status_o <= 8'h00;
      csr_update_o         <= 1'b0;
    end else begin
      tgl_s_q      <= {tgl_s_q[1:0], tgl_q};
      csr_update_o <= tgl_s_q[2] ^ tgl_s_q[1];
      if (tgl_s_q[2] ^ tgl_s_q[1]) begin
        control_and_status_o <= csr_byte;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_UNLOCK_NEEDS_EN: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(unlock_q) |-> $past(wr_en_q))
    else $error("unlock bit set without enable latch");

  AST_LOCK_NEEDS_UNLOCK: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (lock_q != $past(lock_q)) |-> ($past(unlock_q) && !unlock_q))
    else $error("lock bits changed without unlock");

  AST_LOCK_HIT_CLEARS: assert property (@(posedge link_clk_i) disable iff (rst_i)
    lock_hit && !csr_we |=> !unlock_q)
    else $error("unlock not cleared on locked write");

  AST_CUR_OK_SOURCE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(cur_ok_q) |-> $past(dummy_q))
    else $error("current read enabled without random read");

  AST_PTR_INC: assert property (@(posedge link_clk_i) disable iff (rst_i)
    rd_load && !is_csr_q |=> ptr_q == $past(ptr_q) + 1'b1)
    else $error("counter did not advance after byte");

  AST_MEM_WE_PERMIT: assert property (@(posedge link_clk_i) disable iff (rst_i)
    mem_we |-> $past(data_ok_q) && !locked(wr_addr_q, lock_q))
    else $error("array written into locked region");

  AST_EN_SET_CMD: assert property (@(posedge link_clk_i) disable iff (rst_i)
    csr_we && wr_data_q == CMD_EN_SET && !unlock_q |=> wr_en_q)
    else $error("02h did not set enable latch");

  AST_STOP_STANDBY: assert property (@(posedge link_clk_i) disable iff (rst_i)
    stop_e |=> state_q == S_IDLE && !sda_oe_q ##1 !sda_oe_q)
    else $error("not in standby after stop");

  AST_NACK_NO_EN: assert property (@(posedge link_clk_i) disable iff (rst_i)
    byte_end && state_q == S_WDATA && !wr_en_q && !is_csr_q |=> !sda_oe_q && state_q == S_IGNORE)
    else $error("data byte acked with enable latch clear");

  AST_CUR_READ_REFUSED: assert property (@(posedge link_clk_i) disable iff (rst_i)
    byte_end && state_q == S_DEV && sh_q == {ID_EEPROM, 1'b1} && !cur_ok_q && !dummy_q
    |=> !sda_oe_q)
    else $error("current read acked while unavailable");

endmodule

// *** verification/bus_master.sv ***
`timescale 1ns/100ps
module bus_master #(
  parameter int PH = 10
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output      logic scl_o,
  output      logic pull_o
);
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  // ****************************************
  // bus phases, each PH falling edges long, except the 4*PH idle after a stop
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // rep lowers scl first so a held ack never looks like a stop
  task automatic start(input bit rep);
    if (rep) begin
      scl_o = 1'b0;
      wt(PH);
    end
    pull_o = 1'b0;
    wt(PH);
    scl_o = 1'b1;
    wt(PH);
    pull_o = 1'b1;
    wt(PH);
  endtask

  task automatic stop();
    scl_o = 1'b0;
    wt(PH);
    pull_o = 1'b1;
    wt(PH);
    scl_o = 1'b1;
    wt(PH);
    pull_o = 1'b0;
    wt(4 * PH);
  endtask

  task automatic bit_x(input logic b, output logic r);
    scl_o = 1'b0;
    wt(PH);
    pull_o = ~b;
    wt(PH);
    scl_o = 1'b1;
    wt(PH);
    r = sda_i;
  endtask

  // address bytes carry the direction in bit 0
  task automatic wbyte(input logic [7:0] d, input int n, output logic ack);
    logic r;
    ack = 1'b0;
    for (int i = 0; i < n; i++) begin
      bit_x(d[7-i], r);
    end
    if (n == 8) begin
      bit_x(1'b1, r);
      ack = ~r;
    end
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'b1, r);
      d = {d[6:0], r};
    end
    // acknowledge is a low data line
    bit_x(~mack, r);
  endtask
endmodule

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
  import eeprom_ctrl_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       link_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       scl, pull, sda_w, sda_oe, sda_d, upd, a;
  logic [7:0] csr_o, d;
  int         err_count, check_count, cyc, ptr, upd_count;
  int         seed = 91406;
  int         mem[256];
  bit         wr_en, unlock, cur_ok;
  bit   [1:0] lock;

  always #4 sys_clk_i = ~sys_clk_i;
  always #7.5 link_clk_i = ~link_clk_i;
  assign sda_w = ~pull & (~sda_oe | sda_d);

  eeprom_read_and_write_enable_ctrl eeprom_read_and_write_enable_ctrl_i (
    .sys_clk_i(sys_clk_i), .link_clk_i(link_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_d), .sda_oe_o(sda_oe), .control_and_status_o(csr_o), .csr_update_o(upd));
  bus_master bus_master_i (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .pull_o(pull));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic exp_csr();
    check(csr_o, {3'h0, lock, unlock, wr_en, 1'h0});
  endtask

  // update pulses, sampled away from the launching edge
  always @(negedge sys_clk_i) begin
    if (upd === 1'b1) upd_count++;
  end

  task automatic head(input logic [6:0] id, input logic [7:0] adr);
    bus_master_i.start(0);
    bus_master_i.wbyte({id, 1'b0}, 8, a);
    check(a, 1'b1);
    bus_master_i.wbyte(adr, 8, a);
    check(a, 1'b1);
  endtask

  // ****************************************
  // model driven operations
  // ****************************************
  task automatic csr_wr(input logic [7:0] v);
    bit e;
    int u;
    u = upd_count;
    e = wr_en || v == CMD_EN_SET || v == CMD_EN_CLR;
    head(ID_CSR, CSR_ADDR);
    bus_master_i.wbyte(v, 8, a);
    check(a, e);
    bus_master_i.stop();
    cur_ok = 0;
    if (e && unlock && !v[2]) {lock, unlock, wr_en} = {v[4:3], 1'b0, v[1]};
    else if (e && v[2] && wr_en) {unlock, wr_en} = {1'b1, v[1]};
    else if (e) wr_en = v[1];
    exp_csr();
    check(8'(upd_count - u), e);
  endtask

  task automatic ee_wr(input logic [7:0] adr, input int n);
    bit e, lk;
    logic [7:0] v;
    int u;
    u = upd_count;
    v = $random(seed);
    lk = lock == 3 || (lock == 2 && adr >= LIM_HALF) || (lock == 1 && adr >= LIM_QUARTER);
    e = wr_en && !lk;
    head(ID_EEPROM, adr);
    bus_master_i.wbyte(v, n, a);
    if (n == 8) check(a, e);
    bus_master_i.stop();
    if (n == 8 && e) mem[adr] = v;
    if (n == 8 && lk) unlock = 0;
    exp_csr();
    check(8'(upd_count - u), n == 8 && lk);
  endtask

  // adr below zero asks for a current-address read
  task automatic rd(input int adr, input int n);
    bit ok;
    ok = adr >= 0 || cur_ok;
    if (adr >= 0) begin
      head(ID_EEPROM, adr[7:0]);
      ptr = adr;
    end
    bus_master_i.start(adr >= 0);
    bus_master_i.wbyte({ID_EEPROM, 1'b1}, 8, a);
    check(a, ok);
    for (int i = 0; ok && i < n; i++) begin
      bus_master_i.rbyte(i < n - 1, d);
      check(d, mem[ptr][7:0]);
      ptr = (ptr + 1) % 256;
    end
    bus_master_i.stop();
    if (adr >= 0) cur_ok = 1;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    exp_csr();
    rd(-1, 1);
    ee_wr(8'h10, 8);
    csr_wr(8'h06);
    $display("test reset_and_refusals done");
    csr_wr(CMD_EN_SET);
    foreach (mem[i]) mem[i] = -1;
    ee_wr(8'hfe, 8);
    ee_wr(8'hff, 8);
    ee_wr(8'h00, 8);
    ee_wr(8'h10, 8);
    ee_wr(8'h11, 8);
    ee_wr(8'h10, 5);
    rd(8'hfe, 3);
    rd(8'h10, 1);
    rd(-1, 1);
    head(ID_EEPROM, 8'hfe);
    bus_master_i.stop();
    ptr = 8'hfe;
    rd(-1, 2);
    $display("test reads done");
    head(ID_CSR, CSR_ADDR);
    bus_master_i.start(1);
    bus_master_i.wbyte({ID_CSR, 1'b1}, 8, a);
    check(a, 1'b1);
    bus_master_i.rbyte(1'b0, d);
    bus_master_i.stop();
    check(d, {3'h0, lock, unlock, wr_en, 1'h0});
    cur_ok = 0;
    rd(-1, 1);
    rd(8'h10, 1);
    rd(-1, 1);
    bus_master_i.start(0);
    bus_master_i.wbyte({ID_POT, 1'b0}, 8, a);
    check(a, 1'b1);
    bus_master_i.stop();
    cur_ok = 0;
    rd(-1, 1);
    bus_master_i.start(0);
    bus_master_i.wbyte({ID_CSR, 1'b1}, 8, a);
    check(a, 1'b0);
    bus_master_i.stop();
    $display("test register_read done");
    for (int l = 1; l < 4; l++) begin
      csr_wr(8'h06);
      csr_wr({3'h0, l[1:0], 3'h2});
      csr_wr(8'h06);
      ee_wr(8'hc0, 8);
      ee_wr(8'hbf, 8);
      ee_wr(8'h7f, 8);
    end
    csr_wr(8'h06);
    csr_wr(CMD_EN_SET);
    rd(8'hbf, 1);
    rd(8'h7f, 1);
    csr_wr(CMD_EN_CLR);
    ee_wr(8'h20, 8);
    $display("test locks done");
    wrap_up();
  end
endmodule
